// >>> hw/iep_irq_enable_priority_regs.sv
// interrupt enable and priority registers with axi4-lite slave
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module iep_irq_enable_priority_regs #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]            s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// peripheral request pulses
	input  wire logic [iep_pkg::NUM_SRC-1:0]  srcEvent,
	// requests toward the core
	output logic [iep_pkg::NUM_SRC-1:0]       reqVec,
	output logic [2:0]                        topLevel
);

	// ======================================================================
	// elaboration check
	if (ADDR_W < 6 || ADDR_W > 32) begin : gBadAddr
		$error("ADDR_W must lie between 6 and 32");
	end

	// ======================================================================
	// decode
	function automatic logic [3:0] regIndex(input logic [ADDR_W-1:0] addr);
		logic [3:0] idx;
		idx = iep_pkg::IDX_NONE;
		for (int k = 0; k < iep_pkg::REG_COUNT; k++) begin
			if (32'(addr) == iep_pkg::REG_OFFSET[k]) begin
				idx = 4'(k);
			end
		end
		return idx;
	endfunction

	function automatic logic [31:0] laneMask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// ======================================================================
	// write channel
	logic [ADDR_W-1:0] awAddr;
	logic              awHeld;
	logic [31:0]       wData;
	logic [3:0]        wStrb;
	logic              wHeld;
	logic              doWrite;
	logic [3:0]        wrIdx;

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wrIdx   = regIndex(awAddr);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awAddr        <= '0;
			awHeld        <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awAddr        <= s_axi_awaddr;
			awHeld        <= 1'b1;
			s_axi_awready <= 1'b0;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wData        <= '0;
			wStrb        <= '0;
			wHeld        <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wData        <= s_axi_wdata;
			wStrb        <= s_axi_wstrb;
			wHeld        <= 1'b1;
			s_axi_wready <= 1'b0;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= iep_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wrIdx == iep_pkg::IDX_NONE) ?
				iep_pkg::RESP_SLVERR : iep_pkg::RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ======================================================================
	// register storage
	logic [31:0]                 regs [0:iep_pkg::REG_COUNT-1];
	logic [iep_pkg::NUM_SRC-1:0] flagVec;

	assign flagVec = regs[iep_pkg::IDX_FLAGS][iep_pkg::NUM_SRC-1:0];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < iep_pkg::REG_COUNT; k++) begin
				regs[k] <= iep_pkg::REG_RESET[k]; // [RULE_06]
			end
		end else begin
			for (int k = 0; k < iep_pkg::REG_COUNT; k++) begin
				if (doWrite && wrIdx == 4'(k)) begin
					// only implemented bits take the write [RULE_05]
					regs[k] <= ((regs[k] & ~laneMask(wStrb)) |
						(wData & laneMask(wStrb))) & iep_pkg::REG_MASK[k];
				end
			end
			// a raised request beats a clear in the same cycle [RULE_16]
			if (srcEvent != '0) begin
				regs[iep_pkg::IDX_FLAGS] <= ((doWrite &&
					wrIdx == 4'(iep_pkg::IDX_FLAGS)) ?
					((regs[iep_pkg::IDX_FLAGS] & ~laneMask(wStrb)) |
					(wData & laneMask(wStrb))) & iep_pkg::REG_MASK[iep_pkg::IDX_FLAGS] :
					regs[iep_pkg::IDX_FLAGS]) | 32'(srcEvent);
			end
		end
	end

	// ======================================================================
	// per-source configuration and request
	iep_pkg::iep_src_cfg_type    cfg [0:iep_pkg::NUM_SRC-1];
	logic [iep_pkg::NUM_SRC-1:0] enVec;
	logic [iep_pkg::NUM_SRC-1:0] liveVec;
	logic [iep_pkg::NUM_SRC-1:0] next_reqVec;
	logic [2:0]                  next_topLevel;

	always_comb begin
		next_topLevel = iep_pkg::LEVEL_OFF;
		for (int i = 0; i < iep_pkg::NUM_SRC; i++) begin
			// enable and level fields placed per map [RULE_07] [RULE_08]
			cfg[i].enable = regs[iep_pkg::SRC_EN_REG[i]][iep_pkg::SRC_EN_BIT[i]];
			// [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13] [RULE_14]
			// [RULE_15] [RULE_17]
			cfg[i].level = regs[iep_pkg::SRC_LVL_REG[i]][iep_pkg::SRC_LVL_LSB[i] +:
				iep_pkg::LEVEL_W];
			enVec[i]   = cfg[i].enable;
			liveVec[i] = cfg[i].level != iep_pkg::LEVEL_OFF; // [RULE_04]
			// flag, enable and live level together [RULE_01] [RULE_18]
			next_reqVec[i] = flagVec[i] && enVec[i] && liveVec[i];
			// level code is the priority itself [RULE_02] [RULE_03]
			if (next_reqVec[i] && cfg[i].level > next_topLevel) begin
				next_topLevel = cfg[i].level;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reqVec   <= '0;
			topLevel <= iep_pkg::LEVEL_OFF;
		end else begin
			reqVec   <= next_reqVec;
			topLevel <= next_topLevel;
		end
	end

	// ======================================================================
	// read channel
	logic [3:0]  rdIdx;
	logic [31:0] rdMask;

	assign rdIdx = regIndex(s_axi_araddr);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= iep_pkg::RESP_OKAY;
			rdMask        <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			if (rdIdx == iep_pkg::IDX_NONE) begin
				s_axi_rdata <= '0;
				s_axi_rresp <= iep_pkg::RESP_SLVERR;
				rdMask      <= '0;
			end else begin
				s_axi_rdata <= regs[rdIdx] & iep_pkg::REG_MASK[rdIdx]; // [RULE_05]
				s_axi_rresp <= iep_pkg::RESP_OKAY;
				rdMask      <= iep_pkg::REG_MASK[rdIdx];
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ======================================================================
	// checks
	logic afterReset;
	logic sevenLive;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			afterReset <= 1'b1;
		end else begin
			afterReset <= 1'b0;
		end
	end

	always_comb begin
		sevenLive = 1'b0;
		for (int i = 0; i < iep_pkg::NUM_SRC; i++) begin
			if (next_reqVec[i] && cfg[i].level == iep_pkg::LEVEL_TOP) begin
				sevenLive = 1'b1;
			end
		end
	end

	a_enable_gates_req: assert property ( // [RULE_01]
		@(posedge ref_clk) disable iff (!reset_n)
		(reqVec & ~$past(enVec)) == '0)
		else $error("request raised for a disabled source");

	a_top_level_seven: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!reset_n)
		sevenLive |=> topLevel == iep_pkg::LEVEL_TOP)
		else $error("level seven request not reported as top");

	a_level_tracks_req: assert property ( // [RULE_03]
		@(posedge ref_clk) disable iff (!reset_n)
		(topLevel != 3'h0) == (reqVec != '0))
		else $error("top level and request vector disagree");

	a_zero_level_idle: assert property ( // [RULE_04]
		@(posedge ref_clk) disable iff (!reset_n)
		(reqVec & ~$past(liveVec)) == '0)
		else $error("request from a source at level zero");

	a_reserved_read_zero: assert property ( // [RULE_05]
		@(posedge ref_clk) disable iff (!reset_n)
		s_axi_rvalid |-> (s_axi_rdata & ~rdMask) == '0)
		else $error("unimplemented bit read as one");

	a_reset_values: assert property ( // [RULE_06]
		@(posedge ref_clk) disable iff (!reset_n)
		afterReset |-> regs[iep_pkg::IDX_PRI0] == iep_pkg::REG_RESET[iep_pkg::IDX_PRI0] &&
			regs[iep_pkg::IDX_PRI14] == iep_pkg::REG_RESET[iep_pkg::IDX_PRI14] &&
			regs[iep_pkg::IDX_EN3] == iep_pkg::REG_RESET[iep_pkg::IDX_EN3] &&
			regs[iep_pkg::IDX_EN4] == iep_pkg::REG_RESET[iep_pkg::IDX_EN4])
		else $error("register not at reset value");

	a_flag_set_wins: assert property ( // [RULE_16]
		@(posedge ref_clk) disable iff (!reset_n)
		(srcEvent != '0) |=> ($past(srcEvent) & ~flagVec) == '0)
		else $error("raised request lost from flag");

	a_write_answer: assert property ( // [RULE_05]
		@(posedge ref_clk) disable iff (!reset_n)
		(awHeld && wHeld && !s_axi_bvalid) |=> s_axi_bvalid ##0
			$stable(regs[iep_pkg::IDX_EN3] & ~iep_pkg::REG_MASK[iep_pkg::IDX_EN3]))
		else $error("write answer missing or reserved bit changed");

	a_read_answer: assert property ( // [RULE_05]
		@(posedge ref_clk) disable iff (!reset_n)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after address");

endmodule

// >>> hw/iep_pkg.sv
// constants, maps and types for the interrupt enable and priority registers
// ==========================================================================
// Overview of operation
// RULE_01: enable bit one passes source, zero masks
// RULE_02: level code 111 is priority seven, highest
// RULE_03: code 001 is priority one, linear between
// RULE_04: level code 000 disables the source
// RULE_05: unimplemented bits read zero, ignore writes
// RULE_06: reset loads levels 100, enables zero
// RULE_07: enable three: fault 15, encoder 10, error 9
// RULE_08: enable four: fault 10, error 9, uart 1
// RULE_09: level zero: 14-12, 10-8, 6-4, 2-0
// RULE_10: level one: 14-12, 10-8, 6-4 only
// RULE_11: level two: 14-12, 10-8, 6-4, 2-0
// RULE_12: level three: 6-4 and 2-0 only
// RULE_13: level four: 14-12, 6-4, 2-0
// RULE_14: level five: 14-12, 10-8, 2-0
// RULE_15: level seven: external pin two at 6-4
// RULE_16: flag reads one once request raised
// RULE_17: level fourteen: encoder 10-8, pwm1 6-4
// RULE_18: request needs flag, enable, nonzero level
package iep_pkg;

	// ======================================================================
	// register map
	localparam int REG_COUNT = 13;
	localparam int IDX_EN3   = 0;
	localparam int IDX_EN4   = 1;
	localparam int IDX_PRI0  = 2;
	localparam int IDX_PRI14 = 9;
	localparam int IDX_FLAGS = 12;
	localparam logic [31:0] REG_OFFSET [0:REG_COUNT-1] = '{
		32'h0000_0000, 32'h0000_0004, 32'h0000_0008, 32'h0000_000C,
		32'h0000_0010, 32'h0000_0014, 32'h0000_0018, 32'h0000_001C,
		32'h0000_0020, 32'h0000_0024, 32'h0000_0028, 32'h0000_002C,
		32'h0000_0030};
	// implemented bits; all else reads zero
	localparam logic [31:0] REG_MASK [0:REG_COUNT-1] = '{
		32'h0000_8600, 32'h0000_0602, 32'h0000_7777, 32'h0000_7770,
		32'h0000_7777, 32'h0000_0077, 32'h0000_7077, 32'h0000_7707,
		32'h0000_0070, 32'h0000_0770, 32'h000F_FFFF, 32'h0000_7777,
		32'h03FF_FFFF};
	localparam logic [31:0] REG_RESET [0:REG_COUNT-1] = '{
		32'h0000_0000, 32'h0000_0000, 32'h0000_4444, 32'h0000_4440,
		32'h0000_4444, 32'h0000_0044, 32'h0000_4044, 32'h0000_4404,
		32'h0000_0040, 32'h0000_0440, 32'h0000_0000, 32'h0000_4444,
		32'h0000_0000};

	// ======================================================================
	// source maps
	localparam int NUM_SRC = 26;
	localparam int LEVEL_W = 3;
	localparam logic [2:0] LEVEL_OFF = 3'h0;
	localparam logic [2:0] LEVEL_TOP = 3'h7;
	localparam int SRC_LVL_REG [0:NUM_SRC-1] = '{
		2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5,
		6, 6, 6, 7, 7, 7, 8, 9, 9, 11, 11, 11, 11};
	localparam int SRC_LVL_LSB [0:NUM_SRC-1] = '{
		12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0,
		12, 4, 0, 12, 8, 0, 4, 8, 4, 0, 4, 8, 12};
	localparam int SRC_EN_REG [0:NUM_SRC-1] = '{
		10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10,
		10, 10, 10, 10, 10, 10, 10, 0, 0, 0, 1, 1, 1};
	localparam int SRC_EN_BIT [0:NUM_SRC-1] = '{
		0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12,
		13, 14, 15, 16, 17, 18, 19, 10, 9, 15, 10, 9, 1};

	// ======================================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] IDX_NONE    = 4'hF;

	// per-source configuration seen by the request logic
	typedef struct packed {
		logic       enable;
		logic [2:0] level;
	} iep_src_cfg_type;

endpackage

// >>> dv/iep_src_model.sv
// peripheral request source model driving one-cycle event pulses
`timescale 1ns/1ps
module iep_src_model (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        reset_n,
	// pulse command from the bench
	input  wire logic                        fire,
	input  wire logic [4:0]                  fireIdx,
	// request pulses toward the block
	output logic      [iep_pkg::NUM_SRC-1:0] srcEvent
);
	// ======================================================================
	// one pulse per command, idle low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			srcEvent <= '0;
		end else begin
			srcEvent <= fire ? (26'h000_0001 << fireIdx) : '0;
		end
	end
endmodule

// >>> dv/iep_irq_enable_priority_regs_test.sv
// self-checking bench for the interrupt enable and priority registers
`timescale 1ns/1ps
module iep_irq_enable_priority_regs_test;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] rst;
		logic [31:0] full;
	} iep_row_type;
	// ======================================================================
	// rows: address, reset value, readback after writing all ones
	localparam iep_row_type ROWS [0:9] = '{
		'{8'h00, 32'h0000_0000, 32'h0000_8600},
		'{8'h04, 32'h0000_0000, 32'h0000_0602},
		'{8'h08, 32'h0000_4444, 32'h0000_7777},
		'{8'h0C, 32'h0000_4440, 32'h0000_7770},
		'{8'h10, 32'h0000_4444, 32'h0000_7777},
		'{8'h14, 32'h0000_0044, 32'h0000_0077},
		'{8'h18, 32'h0000_4044, 32'h0000_7077},
		'{8'h1C, 32'h0000_4404, 32'h0000_7707},
		'{8'h20, 32'h0000_0040, 32'h0000_0070},
		'{8'h24, 32'h0000_0440, 32'h0000_0770}
	};
	// expected level per source once every level register holds 1234
	localparam logic [2:0] SRC_LEVEL [0:25] = '{
		3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4,
		3'h1, 3'h3, 3'h4, 3'h1, 3'h2, 3'h4, 3'h3, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1};
	logic        ref_clk, reset_n, fire;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [25:0] srcEvent, reqVec;
	logic [2:0]  topLevel;
	logic [4:0]  fireIdx;
	int          errCount, checked;

	iep_irq_enable_priority_regs u_iep_irq_enable_priority_regs (.ref_clk, .reset_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .srcEvent, .reqVec, .topLevel);
	iep_src_model u_iep_src_model (.ref_clk, .reset_n, .fire, .fireIdx, .srcEvent);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ======================================================================
	// compares and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t response %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input int i);
		@(posedge ref_clk);
		fire <= 1'b1;
		fireIdx <= 5'(i);
		@(posedge ref_clk);
		fire <= 1'b0;
	endtask
	task automatic settle(input logic [25:0] e, input logic [2:0] l);
		repeat (4) @(posedge ref_clk);
		#1;
		chk({6'h00, reqVec}, {6'h00, e});
		chk({29'h0000_0000, topLevel}, {29'h0000_0000, l});
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#100us;
		errCount++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end

	// ======================================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{reset_n, fire, fireIdx, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		errCount = 0;
		checked = 0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			axi_read(ROWS[k].addr, d, r);
			chk(d, ROWS[k].rst);
			axi_write(ROWS[k].addr, 32'hFFFF_FFFF, r);
			chk_resp(r, iep_pkg::RESP_OKAY);
			axi_read(ROWS[k].addr, d, r);
			chk(d, ROWS[k].full);
		end
		$display("register table test done");
		axi_read(8'hFC, d, r);
		chk(d, 32'h0000_0000);
		chk_resp(r, iep_pkg::RESP_SLVERR);
		axi_write(8'hFC, 32'hFFFF_FFFF, r);
		chk_resp(r, iep_pkg::RESP_SLVERR);
		$display("unmapped access test done");
		axi_write(8'h28, 32'h0000_0001, r);
		for (int lv = 0; lv < 8; lv++) begin
			axi_write(8'h30, 32'h0000_0000, r);
			axi_write(8'h08, 32'(lv) << 12, r);
			pulse(0);
			settle((lv != 0) ? 26'h000_0001 : 26'h000_0000, 3'(lv));
		end
		axi_read(8'h30, d, r);
		chk(d, 32'h0000_0001);
		$display("priority level test done");
		axi_write(8'h30, 32'h0000_0000, r);
		axi_write(8'h00, 32'h0000_0600, r);
		pulse(22);
		settle(26'h000_0000, 3'h0);
		axi_write(8'h00, 32'h0000_8600, r);
		settle(26'h040_0000, 3'h4);
		pulse(25);
		settle(26'h240_0000, 3'h4);
		$display("enable mask test done");
		s_axi_wstrb <= 4'h1;
		axi_write(8'h08, 32'hFFFF_FFFF, r);
		s_axi_wstrb <= 4'hF;
		axi_read(8'h08, d, r);
		chk(d, 32'h0000_7077);
		$display("byte lane test done");
		for (int a = 8; a <= 44; a += 4) begin
			axi_write(8'(a), 32'h0000_1234, r);
		end
		axi_write(8'h28, 32'h000F_FFFF, r);
		for (int i = 0; i < 26; i++) begin
			axi_write(8'h30, 32'h0000_0000, r);
			pulse(i);
			settle(26'h000_0001 << i, SRC_LEVEL[i]);
		end
		$display("source map test done");
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({6'h00, reqVec}, 32'h0000_0000);
		chk({29'h0000_0000, topLevel}, 32'h0000_0000);
		reset_n <= 1'b1;
		axi_read(8'h00, d, r);
		chk(d, 32'h0000_0000);
		$display("mid-run reset test done");
		end_sim();
	end
endmodule
